// >>> stpseq_pkg.sv
/*
  Constants, register map and pattern tables of the stepper phase sequencer.
  Assumes one 125 MHz system clock and a 32-bit APB register bus.
*/
package stpseq_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] STPSEQ_OFF_CTRL = 8'h00;
  localparam logic [7:0] STPSEQ_OFF_STEP_IV = 8'h04;
  localparam logic [7:0] STPSEQ_OFF_DEAD_IV = 8'h08;
  localparam logic [7:0] STPSEQ_OFF_COUNT = 8'h0C;
  localparam logic [7:0] STPSEQ_OFF_TARGET = 8'h10;
  localparam logic [7:0] STPSEQ_OFF_STATUS = 8'h14;

  // ==========================================================
  // Control and status fields
  localparam int STPSEQ_CTRL_RUN = 0;
  localparam int STPSEQ_CTRL_HALF = 1;
  localparam int STPSEQ_CTRL_DEAD = 2;
  localparam int STPSEQ_CTRL_REV = 3;
  localparam int STPSEQ_CTRL_STBY = 4;
  localparam int STPSEQ_ST_PHASE = 0;
  localparam int STPSEQ_ST_INDEX = 4;
  localparam int STPSEQ_ST_RUNNING = 8;
  localparam int STPSEQ_ST_DONE = 9;

  // ==========================================================
  // Reset values and timing
  localparam logic [4:0] STPSEQ_CTRL_RST = 5'h00;
  localparam logic [15:0] STPSEQ_STEP_IV_RST = 16'h0300;
  localparam logic [15:0] STPSEQ_DEAD_IV_RST = 16'h0030;
  localparam logic [31:0] STPSEQ_TARGET_RST = 32'h0000_0000;
  localparam logic [3:0] STPSEQ_PHASE_RST = 4'h0;
  localparam logic [15:0] STPSEQ_MIN_HOLD = 16'h0002;

  // ==========================================================
  // Sequence modes and tables, entry 0 first
  typedef enum logic [1:0] {
    STPSEQ_FULL = 2'b00,
    STPSEQ_HALFSTEP = 2'b01,
    STPSEQ_DEADTIME = 2'b10
  } stpseq_mode_e;

  localparam logic [3:0] STPSEQ_FULL_LEN = 4'h4;
  localparam logic [3:0] STPSEQ_LONG_LEN = 4'h8;
  localparam logic [3:0] STPSEQ_FULL_TAB [4] = '{4'h9, 4'hA, 4'h6, 4'h5};
  localparam logic [3:0] STPSEQ_HALF_TAB [8] =
    '{4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9};
  localparam logic [3:0] STPSEQ_DEAD_TAB [4] = '{4'h1, 4'h8, 4'h2, 4'h4};

endpackage

// >>> stpseq_ctrl_if.sv
/*
  Interface between the register slave and the sequencer core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface stpseq_ctrl_if;
  logic run;
  logic half;
  logic dead_en;
  logic reverse;
  logic standby;
  logic [15:0] step_iv;
  logic [15:0] dead_iv;
  logic [31:0] target;
  logic count_clr;
  logic [31:0] step_count;
  logic [3:0] phase;
  logic [2:0] index;
  logic running;
  logic done;

  modport regs (
    output run, half, dead_en, reverse, standby, step_iv, dead_iv, target, count_clr,
    input step_count, phase, index, running, done
  );
  modport core (
    input run, half, dead_en, reverse, standby, step_iv, dead_iv, target, count_clr,
    output step_count, phase, index, running, done
  );
endinterface // stpseq_ctrl_if

// >>> stpseq_table.sv
/*
  Pattern lookup: maps sequence mode and index to the phase pattern.
  Assumes the index is already below the length of the selected sequence.
*/
`timescale 1ns/1ps
module stpseq_table
  import stpseq_pkg::*;
(
  // Selection
  input wire stpseq_pkg::stpseq_mode_e mode_in,
  input wire logic [2:0] index_in,
  // Result
  output logic [3:0] pattern_out,
  output logic is_dead_out
);

  // ==========================================================
  // Lookup
  always_comb begin
    pattern_out = STPSEQ_PHASE_RST;
    is_dead_out = 1'b0;
    case (mode_in)
      STPSEQ_FULL: begin
        pattern_out = STPSEQ_FULL_TAB[index_in[1:0]];
      end
      STPSEQ_HALFSTEP: begin
        pattern_out = STPSEQ_HALF_TAB[index_in];
      end
      STPSEQ_DEADTIME: begin
        // Even entries are dead patterns, odd ones the full step they lead into
        is_dead_out = ~index_in[0];
        if (index_in[0]) begin
          pattern_out = STPSEQ_FULL_TAB[index_in[2:1]];
        end else begin
          pattern_out = STPSEQ_DEAD_TAB[index_in[2:1]];
        end
      end
      default: begin
        pattern_out = STPSEQ_PHASE_RST;
      end
    endcase
  end

endmodule // stpseq_table

// >>> stpseq_apb.sv
/*
  APB register slave of the stepper sequencer.
  Assumes a standard APB master on the same clock; one wait state per access.
*/
`timescale 1ns/1ps
module stpseq_apb
  import stpseq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Core side
  stpseq_ctrl_if.regs ctl
);

  logic [4:0] ctrl_reg, ctrl_next;
  logic [15:0] step_iv_reg, step_iv_next;
  logic [15:0] dead_iv_reg, dead_iv_next;
  logic [31:0] target_reg, target_next;
  logic clr_reg, clr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic access;
  logic hit;
  logic [31:0] rdata;

  // ==========================================================
  // Decode
  always_comb begin
    // Waiting one cycle in the access phase keeps read data a clean flop output
    access = psel_in & penable_in & ~pready_reg;
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr_in)
      STPSEQ_OFF_CTRL: rdata = {27'h0000000, ctrl_reg};
      STPSEQ_OFF_STEP_IV: rdata = {16'h0000, step_iv_reg};
      STPSEQ_OFF_DEAD_IV: rdata = {16'h0000, dead_iv_reg};
      STPSEQ_OFF_COUNT: rdata = ctl.step_count;
      STPSEQ_OFF_TARGET: rdata = target_reg;
      STPSEQ_OFF_STATUS: begin
        rdata[STPSEQ_ST_PHASE +: 4] = ctl.phase;
        rdata[STPSEQ_ST_INDEX +: 3] = ctl.index;
        rdata[STPSEQ_ST_RUNNING] = ctl.running;
        rdata[STPSEQ_ST_DONE] = ctl.done;
      end
      default: hit = 1'b0;
    endcase
    ctrl_next = ctrl_reg;
    step_iv_next = step_iv_reg;
    dead_iv_next = dead_iv_reg;
    target_next = target_reg;
    clr_next = 1'b0;
    pready_next = access;
    pslverr_next = access & ~hit;
    prdata_next = (access & ~pwrite_in) ? rdata : 32'h0000_0000;
    if (access & pwrite_in) begin
      case (paddr_in)
        STPSEQ_OFF_CTRL: ctrl_next = pwdata_in[4:0];
        STPSEQ_OFF_STEP_IV: step_iv_next = pwdata_in[15:0];
        STPSEQ_OFF_DEAD_IV: dead_iv_next = pwdata_in[15:0];
        STPSEQ_OFF_COUNT: clr_next = 1'b1;
        STPSEQ_OFF_TARGET: target_next = pwdata_in;
        default: clr_next = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_reg <= STPSEQ_CTRL_RST;
      step_iv_reg <= STPSEQ_STEP_IV_RST;
      dead_iv_reg <= STPSEQ_DEAD_IV_RST;
      target_reg <= STPSEQ_TARGET_RST;
      clr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      step_iv_reg <= step_iv_next;
      dead_iv_reg <= dead_iv_next;
      target_reg <= target_next;
      clr_reg <= clr_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign ctl.run = ctrl_reg[STPSEQ_CTRL_RUN];
  assign ctl.half = ctrl_reg[STPSEQ_CTRL_HALF];
  assign ctl.dead_en = ctrl_reg[STPSEQ_CTRL_DEAD];
  assign ctl.reverse = ctrl_reg[STPSEQ_CTRL_REV];
  assign ctl.standby = ctrl_reg[STPSEQ_CTRL_STBY];
  assign ctl.step_iv = step_iv_reg;
  assign ctl.dead_iv = dead_iv_reg;
  assign ctl.target = target_reg;
  assign ctl.count_clr = clr_reg;

endmodule // stpseq_apb

// >>> stpseq_top.sv
/*
  Stepper phase sequencer: APB registers, interval timer, index walk and
  the four phase pins with their output enables.
  Assumes external pull-downs on the phase lines and an APB master on MCLK_IN.
*/
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module stpseq_top
  import stpseq_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Phase lines, bit 3 is phase_line_3
  output logic [3:0] PHASE_OUT,
  output logic [3:0] PHASE_OE_OUT
);

  stpseq_ctrl_if ctl ();

  stpseq_mode_e mode;
  logic [3:0] seq_len;
  logic [2:0] idx_reg, idx_next;
  logic [2:0] walk_idx;
  logic [15:0] hold_reg, hold_next;
  logic shown_reg, shown_next;
  logic [3:0] phase_reg, phase_next;
  logic [3:0] oe_reg, oe_next;
  logic [31:0] count_reg, count_next;
  logic done;
  logic stepping;
  logic advance;
  logic [3:0] pattern;
  logic is_dead;
  logic [15:0] iv;

  // ==========================================================
  // Register slave
  stpseq_apb u_apb (
    .clk_in(MCLK_IN),
    .srst_in(SRST_IN),
    .psel_in(PSEL_IN),
    .penable_in(PENABLE_IN),
    .pwrite_in(PWRITE_IN),
    .paddr_in(PADDR_IN),
    .pwdata_in(PWDATA_IN),
    .prdata_out(PRDATA_OUT),
    .pready_out(PREADY_OUT),
    .pslverr_out(PSLVERR_OUT),
    .ctl(ctl.regs)
  );

  // ==========================================================
  // Mode and index walk
  always_comb begin
    // Dead-time mode wins over half-step when both are set
    if (ctl.dead_en) begin
      mode = STPSEQ_DEADTIME;
    end else if (ctl.half) begin
      mode = STPSEQ_HALFSTEP;
    end else begin
      mode = STPSEQ_FULL;
    end
    seq_len = (mode == STPSEQ_FULL) ? STPSEQ_FULL_LEN : STPSEQ_LONG_LEN;
    done = (ctl.target != 32'h0000_0000) && (count_reg >= ctl.target);
    stepping = ctl.run & ~done & ~ctl.standby;
    advance = stepping & shown_reg & (hold_reg == 16'h0000);
    walk_idx = idx_reg;
    if ({1'b0, idx_reg} >= seq_len) begin
      // A switch to a shorter table leaves the index outside it
      walk_idx = 3'h0;
    end else if (advance) begin
      if (ctl.reverse) begin
        if (idx_reg == 3'h0) begin
          walk_idx = 3'(seq_len - 4'h1);
        end else begin
          walk_idx = idx_reg - 3'h1;
        end
      end else if ({1'b0, idx_reg} == seq_len - 4'h1) begin
        walk_idx = 3'h0;
      end else begin
        walk_idx = idx_reg + 3'h1;
      end
    end
  end

  stpseq_table u_table (
    .mode_in(mode),
    .index_in(walk_idx),
    .pattern_out(pattern),
    .is_dead_out(is_dead)
  );

  // ==========================================================
  // Interval timer, phase pins and step count
  always_comb begin
    iv = is_dead ? ctl.dead_iv : ctl.step_iv;
    // A hold below two cycles would let the pattern change on back-to-back edges
    if (iv < STPSEQ_MIN_HOLD) begin
      iv = STPSEQ_MIN_HOLD;
    end
    idx_next = walk_idx;
    hold_next = hold_reg;
    shown_next = shown_reg;
    phase_next = phase_reg;
    oe_next = ctl.standby ? 4'h0 : 4'hF;
    count_next = ctl.count_clr ? 32'h0000_0000 : count_reg;
    if (stepping && (!shown_reg || advance)) begin
      phase_next = pattern;
      hold_next = iv - 16'h0001;
      shown_next = 1'b1;
      if (!is_dead) begin
        // Set wins: a step issued with a clear leaves a count of one
        count_next = count_next + 32'h0000_0001;
      end
    end else if (stepping && hold_reg != 16'h0000) begin
      hold_next = hold_reg - 16'h0001;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      idx_reg <= 3'h0;
      hold_reg <= 16'h0000;
      shown_reg <= 1'b0;
      phase_reg <= STPSEQ_PHASE_RST;
      oe_reg <= 4'hF;
      count_reg <= 32'h0000_0000;
    end else begin
      idx_reg <= idx_next;
      hold_reg <= hold_next;
      shown_reg <= shown_next;
      phase_reg <= phase_next;
      oe_reg <= oe_next;
      count_reg <= count_next;
    end
  end

  assign PHASE_OUT = phase_reg;
  assign PHASE_OE_OUT = oe_reg;
  assign ctl.step_count = count_reg;
  assign ctl.phase = phase_reg;
  assign ctl.index = idx_reg;
  assign ctl.running = stepping;
  assign ctl.done = done;

endmodule // stpseq_top

// >>> stpseq_properties.sv
/*
  Checker of the stepper sequencer top ports, bound to the top module.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module stpseq_properties (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  // APB
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Phase lines
  input wire logic [3:0] PHASE_OUT,
  input wire logic [3:0] PHASE_OE_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  // ==========================================================
  // Sequences
  sequence access_s; PSEL_IN && PENABLE_IN && !PREADY_OUT; endsequence
  sequence answer_s; PREADY_OUT ##1 !PREADY_OUT; endsequence
  sequence step_s; $changed(PHASE_OUT); endsequence
  // ==========================================================
  // Properties
  wait_state_a: assert property (access_s |=> answer_s)
    else $error("ready not one cycle after access");
  ready_cause_a: assert property (PREADY_OUT |-> $past(PSEL_IN) && $past(PENABLE_IN))
    else $error("ready without access");
  idle_data_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data outside answer");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  reset_idle_a: assert property ($fell(SRST_IN) |-> PHASE_OUT == 4'h0 && PHASE_OE_OUT == 4'hF)
    else $error("phase lines not idle after reset");
  hold_two_a: assert property (step_s |=> $stable(PHASE_OUT))
    else $error("pattern advanced on consecutive cycles");
  legal_step_a: assert property (step_s |-> PHASE_OUT inside {4'h1, 4'h2, 4'h4, 4'h5,
    4'h6, 4'h8, 4'h9, 4'hA})
    else $error("pattern outside the tables");
  oe_group_a: assert property (PHASE_OE_OUT == 4'h0 || PHASE_OE_OUT == 4'hF)
    else $error("phase enables split");
  stby_freeze_a: assert property ((PHASE_OE_OUT == 4'h0) [*2] |-> $stable(PHASE_OUT))
    else $error("pattern moved in standby");
endmodule // stpseq_properties

bind stpseq_top stpseq_properties u_stpseq_properties (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PHASE_OUT(PHASE_OUT),
  .PHASE_OE_OUT(PHASE_OE_OUT));

// >>> stpseq_coil_model.sv
/*
  Driver input stage: four phase lines with pull-downs.
  Assumes bit i of the phase bus feeds winding i.
*/
`timescale 1ns/1ps
module stpseq_coil_model (
  // From the sequencer
  input wire logic [3:0] phase_in,
  input wire logic [3:0] oe_in,
  // Winding drive
  output logic [3:0] line_out
);
  // A released line falls to its pull-down, so the winding stays off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line_out[i] = oe_in[i] ? phase_in[i] : 1'b0;
    end
  end
endmodule // stpseq_coil_model

// >>> stpseq_tb.sv
/*
  Self-checking bench of the stepper sequencer with an APB master.
  Assumes a 125 MHz clock and the designer's register map.
*/
`timescale 1ns/1ps
module tb;
  import stpseq_pkg::*;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] phase, oe, coil, prev = 4'h0;
  logic [3:0] pq[$];
  int tq[$];
  int n_mismatch = 0, n_checks = 0, seed = 58, cyc = 0, siv, div;
  logic [7:0] ra[5] = '{STPSEQ_OFF_CTRL, STPSEQ_OFF_STEP_IV, STPSEQ_OFF_DEAD_IV,
    STPSEQ_OFF_TARGET, 8'h18};
  logic [31:0] rv[5] = '{32'h0, 32'h300, 32'h30, 32'h0, 32'h0};

  always #4 mclk = ~mclk;

  stpseq_top u_stpseq_top (.MCLK_IN(mclk), .SRST_IN(srst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PHASE_OUT(phase), .PHASE_OE_OUT(oe));
  stpseq_coil_model u_stpseq_coil_model (.phase_in(phase), .oe_in(oe), .line_out(coil));

  // ==========================================================
  // Pattern change log
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (phase !== prev) begin
      pq.push_back(phase);
      tq.push_back(cyc);
      prev = phase;
    end
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_hold(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for ready with no limit of its own; only the watchdog ends a hung transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst_dut();
    srst <= 1'b1;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    pq.delete();
    tq.delete();
  endtask

  // ==========================================================
  // Reference model: index walk, table and hold of entry i
  function automatic int idx_of(input logic [4:0] c, input int i);
    int len;
    len = (c[1] | c[2]) ? 8 : 4;
    return c[3] ? (len - i % len) % len : i % len;
  endfunction
  function automatic logic [3:0] exp_pat(input logic [4:0] c, input int i);
    int x;
    x = idx_of(c, i);
    if (c[2]) return x % 2 ? STPSEQ_FULL_TAB[x / 2] : STPSEQ_DEAD_TAB[x / 2];
    return c[1] ? STPSEQ_HALF_TAB[x] : STPSEQ_FULL_TAB[x];
  endfunction
  function automatic int hold_of(input logic [4:0] c, input int i);
    int iv;
    iv = (c[2] && idx_of(c, i) % 2 == 0) ? div : siv;
    return iv < 2 ? 2 : iv;
  endfunction

  // Target of nine steps stops the walk, a count clear resumes it
  task automatic run_mode(input logic [4:0] c);
    int n, k;
    rst_dut();
    siv = 1 + ($random(seed) & 7);
    div = $random(seed) & 7;
    apb(1'b1, STPSEQ_OFF_STEP_IV, siv);
    apb(1'b1, STPSEQ_OFF_DEAD_IV, div);
    apb(1'b1, STPSEQ_OFF_TARGET, 32'h9);
    apb(1'b1, STPSEQ_OFF_CTRL, {27'h0, c});
    n = c[2] ? 18 : 9;
    for (k = 0; k < 3000 && pq.size() < n; k++) @(posedge mclk);
    repeat (20) @(posedge mclk);
    chk_hold(pq.size(), n);
    for (k = 0; k < n; k++) begin
      chk_val(pq[k], exp_pat(c, k));
      if (k > 0) chk_hold(tq[k] - tq[k - 1], hold_of(c, k - 1));
    end
    chk_val(coil, pq[n - 1]);
    apb(1'b0, STPSEQ_OFF_COUNT, 32'h0);
    chk_val(rd, 32'h9);
    apb(1'b0, STPSEQ_OFF_STATUS, 32'h0);
    chk_val({rd[9:8], rd[6:0]}, {2'b10, 3'(idx_of(c, n - 1)), exp_pat(c, n - 1)});
    apb(1'b1, STPSEQ_OFF_COUNT, 32'h0);
    for (k = 0; k < 100 && pq.size() <= n; k++) @(posedge mclk);
    chk_val(pq[n], exp_pat(c, n));
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    results();
  end

  initial begin
    int sz;
    rst_dut();
    chk_val({phase, oe}, 8'h0F);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk_val(rd, rv[i]);
      chk_val(er, i == 4);
    end
    for (int m = 0; m < 8; m++) run_mode({1'b0, m[2:0], 1'b1});
    apb(1'b1, STPSEQ_OFF_CTRL, 32'h1F);
    repeat (3) @(posedge mclk);
    sz = pq.size();
    chk_val({oe, coil}, 8'h00);
    repeat (30) @(posedge mclk);
    chk_hold(pq.size(), sz);
    apb(1'b1, STPSEQ_OFF_CTRL, 32'h0F);
    repeat (3) @(posedge mclk);
    chk_val(oe, 4'hF);
    results();
  end
endmodule // tb
